// >>> inc/flash_read_consts.svh
`ifndef FLASH_READ_CONSTS_SVH
`define FLASH_READ_CONSTS_SVH

// Opcodes
`define OPC_SLOW 8'h03
`define OPC_QUICK 8'h0b
`define OPC_TWO_OUT 8'h3b
`define OPC_FOUR_OUT 8'h6b
`define OPC_TWO_IO 8'hbb
`define OPC_EXIT 8'hff

// Last bit-slot index of each phase
`define CMD_LAST 5'h07
`define ADDR_LAST_ONE 5'h17
`define ADDR_LAST_TWO 5'h0b
`define MODE_LAST 5'h03
`define DUMMY_LAST 5'h07

// Last output group of a byte per lane mode
`define GRP_LAST_ONE 3'h7
`define GRP_LAST_TWO 3'h3
`define GRP_LAST_FOUR 3'h1

// Lanes driven per lane mode
`define MASK_ONE 4'h2
`define MASK_TWO 4'h3
`define MASK_FOUR 4'hf
`define HOST_MASK_ONE 4'h1
`define HOST_MASK_TWO 4'h3

// Mode byte, config and short-frame limit
`define CONT_NIBBLE 4'ha
`define CFG_QUAD_BIT 1
`define SHORT_FRAME_RISES 5'h08
`define RISES_SAT 5'h1f

// Synchroniser reset: sclk low, select high, lanes high
`define PIN_RST 6'h1f
`define LANE_RST 4'hf

// Timing and sizes
`define CLK_PERIOD_NS 10
`define SCLK_PERIOD_NS 160
`define SLOW_MAX_MHZ 40
`define QUICK_MAX_MHZ 104
`define MULTI_MAX_MHZ 80
`define MIN_SCLK_HALF 6
`define HOST_DESEL_CYCLES 8
`define DEV_MEM_AW 8
`define ADDR_BITS 24

`endif

// >>> inc/flash_read_pkg.sv
`include "flash_read_consts.svh"
package flash_read_pkg;

	typedef enum logic [1:0] {LM_ONE, LM_TWO, LM_FOUR} lane_mode_t;

	typedef enum logic [2:0] {CK_SLOW, CK_QUICK, CK_TWO_OUT, CK_FOUR_OUT,
		CK_TWO_IO, CK_EXIT} cmd_kind_t;

	typedef enum logic [2:0] {DS_IDLE, DS_CMD, DS_ADDR, DS_MODE, DS_DUMMY,
		DS_DATA, DS_IGNORE} dev_state_t;

	typedef enum logic [2:0] {HS_IDLE, HS_CMD, HS_ADDR, HS_MODE, HS_DUMMY,
		HS_DATA, HS_GAP} host_state_t;

	function automatic logic [2:0] grp_last(lane_mode_t m);
		logic [2:0] r;
		r = `GRP_LAST_FOUR;
		unique case (m)
		LM_ONE: r = `GRP_LAST_ONE;
		LM_TWO: r = `GRP_LAST_TWO;
		default: r = `GRP_LAST_FOUR;
		endcase
		return r;
	endfunction

	// Shift lanes in, highest lane as most significant
	function automatic logic [23:0] shift_in(logic [23:0] sr, logic [3:0] ln,
		logic one, lane_mode_t m);
		logic [23:0] r;
		r = sr;
		unique case (m)
		LM_ONE: r = {sr[22:0], one};
		LM_TWO: r = {sr[21:0], ln[1:0]};
		default: r = {sr[19:0], ln};
		endcase
		return r;
	endfunction

endpackage

// >>> inc/flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if;
	logic sclk;
	logic select_bar;
	logic [3:0] host_out;
	logic [3:0] host_oe;
	logic [3:0] dev_out;
	logic [3:0] dev_oe;
	logic [3:0] lane;

	// Wire level: host wins, then device, else pulled high
	assign lane = (host_oe & host_out) | (~host_oe & dev_oe & dev_out)
		| (~host_oe & ~dev_oe);

	modport dev (input sclk, input select_bar, input lane,
		output dev_out, output dev_oe);
	modport host (output sclk, output select_bar, output host_out,
		output host_oe, input lane);
endinterface

// >>> hw/flash_dev.sv
`timescale 1ns/1ps
`include "flash_read_consts.svh"
// Contract
// - Select low, opcode, 24-bit address, sampled rising
// - Single-line data changes on falling clock
// - Host keeps slow fetch at most 40 MHz
// - Quick fetch: dummy byte, then data, 104 MHz
// - Address increments after every data byte
// - Past top address, counter wraps to zero
// - Select high ends fetch, drivers released
// - Fetch refused while internal operation busy
// - Two-lane output read: two bits per fall
// - Four-lane output read: four bits per fall
// - Four-lane read needs config quad bit
// - Two-lane address and mode bits in
// - Mode upper nibble decides, lower ignored
// - Nibble A: next frame skips the opcode
// - Other nibble: next frame needs opcode
// - Short select pulse exits continuous mode
// - Host releases lanes before first data fall
// - Quick fetch opcode 0b, address, dummy, data
module flash_dev #(
	parameter int MEM_AW = `DEV_MEM_AW
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// Link
	flash_link_if.dev link,
	// Array loading
	input wire logic load_en,
	input wire logic [MEM_AW-1:0] load_addr,
	input wire logic [7:0] load_data,
	// Device status
	input wire logic busy,
	input wire logic [7:0] config_reg,
	output logic fetch_active,
	output logic execute_in_place
);

	if (MEM_AW < 1 || MEM_AW > `ADDR_BITS)
	begin : g_bad_aw
		$error("flash_dev: MEM_AW out of range");
	end

	localparam int MEM_DEPTH = 2 ** MEM_AW;

	logic [7:0] mem_r [MEM_DEPTH];
	logic [5:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
	flash_read_pkg::dev_state_t st_r;
	flash_read_pkg::lane_mode_t lm_r;
	logic in_dual_r, has_dummy_r, cont_r;
	logic [4:0] cnt_r, frame_rises_r;
	logic [23:0] sr_r, addr_r;
	logic [7:0] byte_r;
	logic [2:0] grp_r;
	logic [3:0] out_r, oe_r;

	// Pin filter: a change counts once stages two and three agree
	wire [5:0] pins = {link.sclk, link.select_bar, link.lane};
	wire [5:0] agree = ~(s2_r ^ s3_r);
	wire [5:0] filt_nxt = (agree & s2_r) | (~agree & filt_r);

	always_ff @(posedge clock)
		if (srst)
		begin
			s1_r <= `PIN_RST;
			s2_r <= `PIN_RST;
			s3_r <= `PIN_RST;
			filt_r <= `PIN_RST;
			filt_d_r <= `PIN_RST;
		end
		else if (ce)
		begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= filt_nxt;
			filt_d_r <= filt_r;
		end

	wire sck_rise = filt_r[5] & ~filt_d_r[5];
	wire sck_fall = ~filt_r[5] & filt_d_r[5];
	wire sel_up = filt_r[4] & ~filt_d_r[4];
	wire sel_down = ~filt_r[4] & filt_d_r[4];
	wire selected = ~filt_r[4];
	wire [3:0] lin = filt_r[3:0];

	// Input shifting and opcode decode
	flash_read_pkg::lane_mode_t in_lm;
	assign in_lm = in_dual_r ? flash_read_pkg::LM_TWO
		: flash_read_pkg::LM_ONE;
	wire [23:0] sr_nxt = flash_read_pkg::shift_in(sr_r, lin, lin[0], in_lm);
	wire [7:0] opc = sr_nxt[7:0];
	wire is_slow = opc == `OPC_SLOW;
	wire is_quick = opc == `OPC_QUICK;
	wire is_two_out = opc == `OPC_TWO_OUT;
	wire is_four = opc == `OPC_FOUR_OUT;
	wire is_two_io = opc == `OPC_TWO_IO;
	wire cmd_known = is_slow | is_quick | is_two_out | is_four | is_two_io;
	wire quad_ok = config_reg[`CFG_QUAD_BIT];
	wire cmd_refused = ~cmd_known | busy | (is_four & ~quad_ok);
	flash_read_pkg::lane_mode_t cmd_lm;
	assign cmd_lm = is_four ? flash_read_pkg::LM_FOUR
		: (is_two_out | is_two_io) ? flash_read_pkg::LM_TWO
		: flash_read_pkg::LM_ONE;
	wire [4:0] addr_last = in_dual_r ? `ADDR_LAST_TWO : `ADDR_LAST_ONE;
	wire mode_keep = sr_nxt[7:4] == `CONT_NIBBLE;
	wire short_frame = frame_rises_r <= `SHORT_FRAME_RISES;

	// Output selection for the next falling edge
	wire [7:0] cur_byte = (grp_r == 3'h0) ? mem_r[addr_r[MEM_AW-1:0]]
		: byte_r;
	wire grp_end = grp_r == flash_read_pkg::grp_last(lm_r);
	logic [3:0] drive, mask;
	logic [7:0] byte_rest;
	always_comb
	begin
		drive = cur_byte[7:4];
		mask = `MASK_FOUR;
		byte_rest = {cur_byte[3:0], 4'h0};
		unique case (lm_r)
		flash_read_pkg::LM_ONE:
		begin
			drive = {2'h0, cur_byte[7], 1'b0};
			mask = `MASK_ONE;
			byte_rest = {cur_byte[6:0], 1'b0};
		end
		flash_read_pkg::LM_TWO:
		begin
			drive = {2'h0, cur_byte[7:6]};
			mask = `MASK_TWO;
			byte_rest = {cur_byte[5:0], 2'h0};
		end
		default:
		begin
			drive = cur_byte[7:4];
			mask = `MASK_FOUR;
			byte_rest = {cur_byte[3:0], 4'h0};
		end
		endcase
	end

	always_ff @(posedge clock)
		if (ce && load_en)
			mem_r[load_addr] <= load_data;

	always_ff @(posedge clock)
		if (srst)
		begin
			st_r <= flash_read_pkg::DS_IDLE;
			lm_r <= flash_read_pkg::LM_ONE;
			in_dual_r <= 1'b0;
			has_dummy_r <= 1'b0;
			cont_r <= 1'b0;
			cnt_r <= 5'h00;
			frame_rises_r <= 5'h00;
			sr_r <= 24'h000000;
			addr_r <= 24'h000000;
			byte_r <= 8'h00;
			grp_r <= 3'h0;
			out_r <= 4'h0;
			oe_r <= 4'h0;
		end
		else if (ce)
		begin
			if (sel_up)
			begin
				st_r <= flash_read_pkg::DS_IDLE;
				oe_r <= 4'h0;
				if (cont_r && short_frame)
					cont_r <= 1'b0;
			end
			else if (sel_down)
			begin
				cnt_r <= 5'h00;
				frame_rises_r <= 5'h00;
				sr_r <= 24'h000000;
				if (!cont_r)
				begin
					// Opcode always comes in on one lane
					st_r <= flash_read_pkg::DS_CMD;
					in_dual_r <= 1'b0;
				end
				else if (busy)
					st_r <= flash_read_pkg::DS_IGNORE;
				else
				begin
					// Continuous mode: address comes first
					st_r <= flash_read_pkg::DS_ADDR;
					lm_r <= flash_read_pkg::LM_TWO;
					in_dual_r <= 1'b1;
					has_dummy_r <= 1'b0;
				end
			end
			else if (selected && sck_rise)
			begin
				sr_r <= sr_nxt;
				cnt_r <= cnt_r + 5'h01;
				if (frame_rises_r != `RISES_SAT)
					frame_rises_r <= frame_rises_r + 5'h01;
				unique case (st_r)
				flash_read_pkg::DS_CMD:
					if (cnt_r == `CMD_LAST)
					begin
						cnt_r <= 5'h00;
						if (cmd_refused)
							st_r <= flash_read_pkg::DS_IGNORE;
						else
						begin
							st_r <= flash_read_pkg::DS_ADDR;
							lm_r <= cmd_lm;
							in_dual_r <= is_two_io;
							has_dummy_r <= ~is_slow & ~is_two_io;
						end
					end
				flash_read_pkg::DS_ADDR:
					if (cnt_r == addr_last)
					begin
						cnt_r <= 5'h00;
						addr_r <= sr_nxt;
						grp_r <= 3'h0;
						if (in_dual_r)
							st_r <= flash_read_pkg::DS_MODE;
						else if (has_dummy_r)
							st_r <= flash_read_pkg::DS_DUMMY;
						else
							st_r <= flash_read_pkg::DS_DATA;
					end
				flash_read_pkg::DS_MODE:
					if (cnt_r == `MODE_LAST)
					begin
						cnt_r <= 5'h00;
						cont_r <= mode_keep;
						st_r <= flash_read_pkg::DS_DATA;
					end
				flash_read_pkg::DS_DUMMY:
					if (cnt_r == `DUMMY_LAST)
					begin
						cnt_r <= 5'h00;
						st_r <= flash_read_pkg::DS_DATA;
					end
				default:
				begin
				end
				endcase
			end
			else if (selected && sck_fall && st_r == flash_read_pkg::DS_DATA)
			begin
				out_r <= drive;
				oe_r <= mask;
				byte_r <= byte_rest;
				grp_r <= grp_end ? 3'h0 : grp_r + 3'h1;
				if (grp_r == 3'h0)
					addr_r <= addr_r + 24'h000001;
			end
		end

	assign link.dev_out = out_r;
	assign link.dev_oe = oe_r;
	assign fetch_active = st_r == flash_read_pkg::DS_DATA;
	assign execute_in_place = cont_r;

endmodule // flash_dev

// >>> hw/flash_host.sv
`timescale 1ns/1ps
`include "flash_read_consts.svh"
module flash_host #(
	parameter int SCLK_HALF = `SCLK_PERIOD_NS / 2 / `CLK_PERIOD_NS,
	parameter int GAP = `HOST_DESEL_CYCLES
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// Link
	flash_link_if.host link,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire flash_read_pkg::cmd_kind_t req_kind,
	input wire logic [23:0] req_addr,
	input wire logic [7:0] req_mode,
	input wire logic req_cont,
	input wire logic [15:0] req_len,
	// Answer
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic done
);

	// Slowest limit covers every command; device filter needs slack
	if (1000 / (2 * SCLK_HALF * `CLK_PERIOD_NS) > `SLOW_MAX_MHZ
		|| SCLK_HALF < `MIN_SCLK_HALF || GAP < 4 || GAP > 255)
	begin : g_bad_param
		$error("flash_host: clock divider or gap out of range");
	end

	flash_read_pkg::host_state_t st_r;
	flash_read_pkg::cmd_kind_t kind_r;
	flash_read_pkg::lane_mode_t lm_r;
	logic [3:0] s1_r, s2_r, s3_r, lin_r;
	logic [15:0] half_r, len_r;
	logic [7:0] gap_r, rx_r, rsp_data_r;
	logic [39:0] tx_r;
	logic [4:0] cnt_r;
	logic [2:0] grp_r;
	logic [3:0] oe_r;
	logic sclk_r, sel_n_r, in_dual_r, rsp_valid_r, done_r;

	// Lane filter, same policy as the device
	wire [3:0] agree = ~(s2_r ^ s3_r);
	always_ff @(posedge clock)
		if (srst)
		begin
			s1_r <= `LANE_RST;
			s2_r <= `LANE_RST;
			s3_r <= `LANE_RST;
			lin_r <= `LANE_RST;
		end
		else if (ce)
		begin
			s1_r <= link.lane;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lin_r <= (agree & s2_r) | (~agree & lin_r);
		end

	wire shifting = st_r != flash_read_pkg::HS_IDLE
		&& st_r != flash_read_pkg::HS_GAP;
	wire half_end = half_r == 16'(SCLK_HALF - 1);
	wire slot_end = shifting & half_end & sclk_r;
	wire accept = req_valid & req_ready & ce;
	wire k_two_io = req_kind == flash_read_pkg::CK_TWO_IO;
	wire k_dummy = kind_r != flash_read_pkg::CK_SLOW
		&& kind_r != flash_read_pkg::CK_TWO_IO;
	wire [4:0] addr_last = in_dual_r ? `ADDR_LAST_TWO : `ADDR_LAST_ONE;
	wire [23:0] rx_wide = flash_read_pkg::shift_in({16'h0000, rx_r},
		lin_r, lin_r[1], lm_r);
	wire grp_end = grp_r == flash_read_pkg::grp_last(lm_r);

	logic [7:0] opc;
	flash_read_pkg::lane_mode_t req_lm;
	always_comb
	begin
		opc = `OPC_SLOW;
		req_lm = flash_read_pkg::LM_ONE;
		unique case (req_kind)
		flash_read_pkg::CK_SLOW: opc = `OPC_SLOW;
		flash_read_pkg::CK_QUICK: opc = `OPC_QUICK;
		flash_read_pkg::CK_TWO_OUT:
		begin
			opc = `OPC_TWO_OUT;
			req_lm = flash_read_pkg::LM_TWO;
		end
		flash_read_pkg::CK_FOUR_OUT:
		begin
			opc = `OPC_FOUR_OUT;
			req_lm = flash_read_pkg::LM_FOUR;
		end
		flash_read_pkg::CK_TWO_IO:
		begin
			opc = `OPC_TWO_IO;
			req_lm = flash_read_pkg::LM_TWO;
		end
		default: opc = `OPC_EXIT;
		endcase
	end

	always_ff @(posedge clock)
		if (srst)
		begin
			st_r <= flash_read_pkg::HS_IDLE;
			kind_r <= flash_read_pkg::CK_SLOW;
			lm_r <= flash_read_pkg::LM_ONE;
			half_r <= 16'h0000;
			len_r <= 16'h0000;
			gap_r <= 8'h00;
			rx_r <= 8'h00;
			rsp_data_r <= 8'h00;
			tx_r <= 40'h0000000000;
			cnt_r <= 5'h00;
			grp_r <= 3'h0;
			oe_r <= 4'h0;
			sclk_r <= 1'b0;
			sel_n_r <= 1'b1;
			in_dual_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			done_r <= 1'b0;
		end
		else if (ce)
		begin
			rsp_valid_r <= 1'b0;
			done_r <= 1'b0;
			if (accept)
			begin
				sel_n_r <= 1'b0;
				sclk_r <= 1'b0;
				half_r <= 16'h0000;
				cnt_r <= 5'h00;
				grp_r <= 3'h0;
				kind_r <= req_kind;
				lm_r <= req_lm;
				len_r <= req_len;
				if (req_cont && k_two_io)
				begin
					// Continuous frame: address first, no opcode
					st_r <= flash_read_pkg::HS_ADDR;
					tx_r <= {req_addr, req_mode, 8'h00};
					in_dual_r <= 1'b1;
					oe_r <= `HOST_MASK_TWO;
				end
				else
				begin
					st_r <= flash_read_pkg::HS_CMD;
					tx_r <= {opc, req_addr, k_two_io ? req_mode : 8'h00};
					in_dual_r <= 1'b0;
					oe_r <= `HOST_MASK_ONE;
				end
			end
			else if (st_r == flash_read_pkg::HS_GAP)
			begin
				gap_r <= gap_r + 8'h01;
				if (gap_r == 8'(GAP - 1))
				begin
					gap_r <= 8'h00;
					done_r <= 1'b1;
					st_r <= flash_read_pkg::HS_IDLE;
				end
			end
			else if (shifting)
			begin
				half_r <= half_end ? 16'h0000 : half_r + 16'h0001;
				if (half_end)
					sclk_r <= ~sclk_r;
			end
			if (slot_end)
			begin
				cnt_r <= cnt_r + 5'h01;
				tx_r <= in_dual_r ? {tx_r[37:0], 2'h0} : {tx_r[38:0], 1'b0};
				unique case (st_r)
				flash_read_pkg::HS_CMD:
					if (cnt_r == `CMD_LAST)
					begin
						cnt_r <= 5'h00;
						if (kind_r == flash_read_pkg::CK_EXIT)
						begin
							st_r <= flash_read_pkg::HS_GAP;
							sel_n_r <= 1'b1;
							oe_r <= 4'h0;
						end
						else
						begin
							st_r <= flash_read_pkg::HS_ADDR;
							if (kind_r == flash_read_pkg::CK_TWO_IO)
							begin
								in_dual_r <= 1'b1;
								oe_r <= `HOST_MASK_TWO;
							end
						end
					end
				flash_read_pkg::HS_ADDR:
					if (cnt_r == addr_last)
					begin
						cnt_r <= 5'h00;
						if (in_dual_r)
							st_r <= flash_read_pkg::HS_MODE;
						else if (k_dummy)
							st_r <= flash_read_pkg::HS_DUMMY;
						else
						begin
							st_r <= flash_read_pkg::HS_DATA;
							oe_r <= 4'h0;
						end
					end
				flash_read_pkg::HS_MODE, flash_read_pkg::HS_DUMMY:
					if (cnt_r == ((st_r == flash_read_pkg::HS_MODE)
						? `MODE_LAST : `DUMMY_LAST))
					begin
						cnt_r <= 5'h00;
						st_r <= flash_read_pkg::HS_DATA;
						in_dual_r <= 1'b0;
						oe_r <= 4'h0;
					end
				default:
				begin
					rx_r <= rx_wide[7:0];
					grp_r <= grp_end ? 3'h0 : grp_r + 3'h1;
					if (grp_end)
					begin
						rsp_valid_r <= 1'b1;
						rsp_data_r <= rx_wide[7:0];
						len_r <= len_r - 16'h0001;
						if (len_r <= 16'h0001)
						begin
							st_r <= flash_read_pkg::HS_GAP;
							sel_n_r <= 1'b1;
						end
					end
				end
				endcase
			end
		end

	assign link.sclk = sclk_r;
	assign link.select_bar = sel_n_r;
	assign link.host_out = in_dual_r ? {2'h0, tx_r[39:38]}
		: {3'h0, tx_r[39]};
	assign link.host_oe = oe_r;
	assign req_ready = st_r == flash_read_pkg::HS_IDLE;
	assign rsp_valid = rsp_valid_r;
	assign rsp_data = rsp_data_r;
	assign done = done_r;

endmodule // flash_host

// >>> testbench/flash_read_asserts.sv
`timescale 1ns/1ps
`include "flash_read_consts.svh"
module flash_read_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Link
	input wire logic sclk,
	input wire logic select_bar,
	input wire logic [3:0] host_out,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe,
	input wire logic [3:0] lane
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	idle_release_a: assert property (select_bar [*6] |-> dev_oe == 4'h0)
		else $error("device drives lanes while deselected");
	frame_quiet_a: assert property ($fell(select_bar) |->
		(dev_oe == 4'h0) [*8])
		else $error("device drives lanes during opcode phase");
	no_contention_a: assert property (host_oe != 4'h0 |->
		(host_oe & dev_oe) == 4'h0)
		else $error("host and device drive a lane together");
	dev_mask_a: assert property (dev_oe != 4'h0 |->
		dev_oe inside {`MASK_ONE, `MASK_TWO, `MASK_FOUR})
		else $error("device lane enable pattern illegal");
	host_mask_a: assert property (host_oe != 4'h0 |->
		host_oe inside {`HOST_MASK_ONE, `HOST_MASK_TWO})
		else $error("host lane enable pattern illegal");
	dev_change_low_a: assert property ($changed(dev_out) &&
		dev_oe != 4'h0 |-> !sclk)
		else $error("device data changed while clock high");
	host_hold_high_a: assert property (sclk && $past(sclk) &&
		host_oe != 4'h0 |-> $stable(host_out & host_oe))
		else $error("host data changed while clock high");
	lane_hold_high_a: assert property (sclk && dev_oe != 4'h0 &&
		host_oe == 4'h0 |-> $stable(lane))
		else $error("lane level moved while clock high");
	sclk_half_a: assert property ($changed(sclk) |=>
		$stable(sclk) [*7])
		else $error("serial clock half period too short");
	idle_clock_a: assert property (select_bar && $past(select_bar) |->
		!sclk)
		else $error("serial clock high while deselected");
	select_gap_a: assert property ($rose(select_bar) |=>
		select_bar [*3])
		else $error("deselect gap too short");
endmodule // flash_read_asserts

// >>> testbench/tb_serial_flash_read_path.sv
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) \
	begin mismatches++; $display("wrong value %s expected %h seen %h", \
	nm, ex, got); end end
module tb_serial_flash_read_path;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic load_en = 1'b0;
	logic [7:0] load_addr = 8'h00;
	logic [7:0] load_data = 8'h00;
	logic busy = 1'b0;
	logic [7:0] config_reg = 8'h02;
	logic req_valid = 1'b0;
	logic req_ready;
	flash_read_pkg::cmd_kind_t req_kind = flash_read_pkg::CK_SLOW;
	logic [23:0] req_addr = 24'h000000;
	logic [7:0] req_mode = 8'h00;
	logic req_cont = 1'b0;
	logic [15:0] req_len = 16'h0001;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic done;
	logic fetch_active;
	logic execute_in_place;
	logic [7:0] mem [256];
	int mismatches = 0;
	int checks_done = 0;

	always #5 clock = ~clock;

	flash_link_if link ();
	flash_dev u_flash_dev (.clock(clock), .srst(srst), .ce(ce),
		.link(link.dev), .load_en(load_en), .load_addr(load_addr),
		.load_data(load_data), .busy(busy), .config_reg(config_reg),
		.fetch_active(fetch_active), .execute_in_place(execute_in_place));
	flash_host u_flash_host (.clock(clock), .srst(srst), .ce(ce),
		.link(link.host), .req_valid(req_valid), .req_ready(req_ready),
		.req_kind(req_kind), .req_addr(req_addr), .req_mode(req_mode),
		.req_cont(req_cont), .req_len(req_len), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .done(done));
	flash_read_asserts u_flash_read_asserts (.clock(clock), .srst(srst),
		.sclk(link.sclk), .select_bar(link.select_bar),
		.host_out(link.host_out), .host_oe(link.host_oe),
		.dev_out(link.dev_out), .dev_oe(link.dev_oe), .lane(link.lane));

	function automatic logic [7:0] exp_byte(input logic [23:0] a);
		return mem[a[7:0]];
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One transaction; refused frames read back as pull-up
	task automatic do_read(input flash_read_pkg::cmd_kind_t k,
		input logic [23:0] a, input logic [7:0] m, input logic c,
		input int n, input logic refused);
		int i;
		int w;
		logic act;
		logic [7:0] exp_v;
		i = 0;
		w = 0;
		act = 1'b0;
		@(posedge clock);
		req_kind <= k;
		req_addr <= a;
		req_mode <= m;
		req_cont <= c;
		req_len <= 16'(n);
		req_valid <= 1'b1;
		@(posedge clock);
		while (req_ready !== 1'b1 && w < 100)
		begin
			@(posedge clock);
			w++;
		end
		req_valid <= 1'b0;
		while (done !== 1'b1 && w < 20000)
		begin
			@(posedge clock);
			w++;
			if (fetch_active === 1'b1)
				act = 1'b1;
			if (rsp_valid === 1'b1)
			begin
				exp_v = refused ? 8'hff : exp_byte(a + 24'(i));
				`CHECK("rsp_data", exp_v, rsp_data)
				i++;
			end
		end
		if (w >= 20000)
		begin
			mismatches++;
			$display("wrong value done expected 1 seen 0");
		end
		if (k != flash_read_pkg::CK_EXIT)
			`CHECK("byte_count", n, i)
		`CHECK("fetch_active", !refused, act)
	endtask

	initial
	begin
		#500000;
		mismatches++;
		$display("wrong value watchdog expected done seen hang");
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(32'h7335ae4c));
		foreach (mem[j])
			mem[j] = 8'($urandom);
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		for (int j = 0; j < 256; j++)
		begin
			@(posedge clock);
			load_en <= 1'b1;
			load_addr <= 8'(j);
			load_data <= mem[j];
		end
		@(posedge clock);
		load_en <= 1'b0;
		for (int k = 0; k < 5; k++)
			do_read(flash_read_pkg::cmd_kind_t'(k), 24'($urandom), 8'h00,
				1'b0, 3, 1'b0);
		// Both ends frozen together in mid-address must still read right
		fork
			do_read(flash_read_pkg::CK_QUICK, 24'($urandom), 8'h00, 1'b0,
				2, 1'b0);
			begin
				repeat (300) @(posedge clock);
				ce <= 1'b0;
				repeat (20) @(posedge clock);
				ce <= 1'b1;
			end
		join
		do_read(flash_read_pkg::CK_SLOW, 24'hfffffe, 8'h00, 1'b0, 4, 1'b0);
		config_reg <= 8'hfd;
		do_read(flash_read_pkg::CK_FOUR_OUT, 24'h000010, 8'h00, 1'b0, 2, 1'b1);
		config_reg <= 8'h02;
		busy <= 1'b1;
		do_read(flash_read_pkg::CK_QUICK, 24'h000020, 8'h00, 1'b0, 2, 1'b1);
		busy <= 1'b0;
		do_read(flash_read_pkg::CK_TWO_IO, 24'h0000f0, 8'ha5, 1'b0, 2, 1'b0);
		`CHECK("execute_in_place", 1'b1, execute_in_place)
		do_read(flash_read_pkg::CK_TWO_IO, 24'h123456, 8'h5a, 1'b1, 2, 1'b0);
		`CHECK("execute_in_place", 1'b0, execute_in_place)
		do_read(flash_read_pkg::CK_SLOW, 24'h0000ff, 8'h00, 1'b0, 2, 1'b0);
		do_read(flash_read_pkg::CK_TWO_IO, 24'h000040, 8'haf, 1'b0, 1, 1'b0);
		do_read(flash_read_pkg::CK_EXIT, 24'h000000, 8'h00, 1'b0, 0, 1'b1);
		`CHECK("execute_in_place", 1'b0, execute_in_place)
		repeat (6)
			do_read(flash_read_pkg::cmd_kind_t'($urandom_range(4, 0)),
				24'($urandom), {4'h0, 4'($urandom)}, 1'b0,
				$urandom_range(3, 1), 1'b0);
		tally_and_finish();
	end
endmodule // tb_serial_flash_read_path
